// ---- rsl_pkg.sv ----
// Package for the reset strap latch: register map, pad masks, types and timing
package rsl_pkg;

  // APB geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
  localparam logic [7:0] OFS_SYS_CFG = 8'h04;
  localparam logic [7:0] OFS_SDRAM_CFG = 8'h08;
  localparam logic [7:0] OFS_IRQ_CFG = 8'h0c;
  localparam logic [7:0] OFS_LINK_CFG = 8'h10;
  localparam logic [7:0] OFS_PIN_DRIVE = 8'h14;

  // Status register field positions
  localparam int STS_STRAP_LSB = 0;
  localparam int STS_VALID_BIT = 7;
  localparam int STS_SYS_LOCK_BIT = 8;
  localparam int STS_SDRAM_LOCK_BIT = 9;
  localparam int STS_TEST_FAULT_BIT = 10;
  localparam int STS_RUN_BIT = 11;
  localparam int STS_BOOT_SEL_LEVEL_BIT = 16;
  localparam int STS_HOLD_LEVEL_BIT = 17;

  // IRQ configuration field positions
  localparam int IRQ_EN_LSB = 0;
  localparam int IRQ_LVL_LSB = 4;

  // Reset values
  localparam logic [31:0] SYS_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SDRAM_CFG_RST = 32'h0000_0000;
  localparam logic [6:0] STRAP_DEFAULT = 7'h70;
  localparam logic [4:0] PIN_DRIVE_RST = 5'h00;

  // Pad indices; pad i carries strap i
  localparam int PAD_BOOT_MEM_SEL = 0;
  localparam int PAD_BUS_MASTER = 1;
  localparam int PAD_TIMER_EXP = 2;
  localparam int PAD_BUS_HOLD = 3;
  localparam int PAD_LINK1_DONE = 4;
  localparam int PAD_LINK2_DONE = 5;
  localparam int PAD_LINK3_DONE = 6;
  localparam int NUM_PADS = 7;

  // Pad termination masks, during reset and in normal operation
  localparam logic [6:0] PULL_UP_RST = 7'h70;
  localparam logic [6:0] PULL_DN_RST = 7'h0f;
  localparam logic [6:0] PULL_UP_RUN = 7'h09;
  localparam logic [6:0] DRIVEN_RUN = 7'h76;
  localparam logic [6:0] ID0_ONLY = 7'h09;

  // Settle time before the pads take their normal functions
  localparam int CLK_PERIOD_NS = 40;
  localparam int RECONFIG_NS = 200;
  localparam int RECONFIG_CYCLES = (RECONFIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Captured mode straps, bit 6 first
  typedef struct packed {
    logic test_strap_three;
    logic test_strap_two;
    logic test_strap_one;
    logic config_write_strap;
    logic link_width_strap;
    logic irq_startup_strap;
    logic boot_source_strap;
  } rsl_strap_t;

  // Pad control bundle
  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
    logic [6:0] pu;
    logic [6:0] pd;
  } rsl_pad_ctl_t;

  // Sequencing states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN = 3'b100
  } rsl_fsm_t;

endpackage

// ---- rsl_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rsl_pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock
  input wire logic clk_in,
  // Raw pins and filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } rsl_sync_state_t;

  rsl_sync_state_t q, d;

  // Level moves only when stages two and three agree
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  // No reset: the chain must keep sampling while reset is held
  always_ff @(posedge clk_in) begin
    q <= d;
  end

  assign level_out = q.lvl;

endmodule

// ---- rsl_reset_strap_latch.sv ----
// Reset strap latch: captures mode straps at reset release, APB register file
//
// What this block does
// - Capture all straps on the first clock edge after reset deassertion.
// - Latch each pin level, use as mode.
// - Return strap pins to normal function afterwards.
// - Apply built-in default pull during reset; pads 0 and 3 only with ID zero.
// - Boot strap: 0 boot EPROM, 1 wait.
// - IRQ strap: 0 disabled/edge, 1 enabled/level.
// - Link width strap: 0 one-bit, 1 four-bit.
// - Write strap: 0 config once, 1 always.
// - Pad termination follows reset state per pin.
`timescale 1ns/1ps
module rsl_reset_strap_latch (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [rsl_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [rsl_pkg::DATA_W-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [rsl_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Dual-purpose strap pads
  input wire logic [rsl_pkg::NUM_PADS-1:0] pad_in,
  output logic [rsl_pkg::NUM_PADS-1:0] pad_out,
  output logic [rsl_pkg::NUM_PADS-1:0] pad_oe_out,
  output logic [rsl_pkg::NUM_PADS-1:0] pad_pu_out,
  output logic [rsl_pkg::NUM_PADS-1:0] pad_pd_out,
  input wire logic dsp_id_zero_in,
  // Mode settings
  output rsl_pkg::rsl_strap_t straps_out,
  output logic settings_valid_out,
  output logic boot_from_eprom_out,
  output logic boot_wait_host_out,
  output logic [3:0] irq_enable_out,
  output logic [3:0] irq_level_out,
  output logic link_width_4bit_out,
  output logic [31:0] system_config_reg_out,
  output logic [31:0] sdram_config_reg_out
);

  import rsl_pkg::*;

  typedef struct packed {
    rsl_fsm_t fsm;
    logic [3:0] cnt;
    rsl_strap_t strap;
    logic valid;
    logic [31:0] sys_cfg;
    logic [31:0] sdram_cfg;
    logic sys_lock;
    logic sdram_lock;
    logic [3:0] irq_en;
    logic [3:0] irq_lvl;
    logic link_w4;
    logic [4:0] pin_drive;
    logic [31:0] prdata;
    logic pslverr;
  } rsl_state_t;

  rsl_state_t q, d;
  logic [NUM_PADS:0] sync_lvl;
  logic [NUM_PADS-1:0] pad_lvl;
  logic id_zero;
  logic running;
  logic [6:0] id_gate;
  logic [31:0] rd_data;
  logic addr_hit;
  logic wr_refused;
  logic setup_phase;
  logic access_wr;
  rsl_pad_ctl_t pad_ctl;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Pads and the ID pin cross in through four flops (three stages and the filter)
  rsl_pin_sync #(
    .WIDTH(NUM_PADS + 1)
  ) u_pin_sync (
    .clk_in(clk_in),
    .pin_in({dsp_id_zero_in, pad_in}),
    .level_out(sync_lvl)
  );

  assign pad_lvl = sync_lvl[NUM_PADS-1:0];
  assign id_zero = sync_lvl[NUM_PADS];
  assign running = (q.fsm == ST_RUN);

  // Pulls marked for ID zero exist only for that device;
  // the gate clears them for every other ID
  assign id_gate = id_zero ? 7'h7f : ~ID0_ONLY;

  // Pad termination and drive by reset phase
  always_comb begin
    pad_ctl.out = '0;
    pad_ctl.out[PAD_BUS_MASTER] = q.pin_drive[0];
    pad_ctl.out[PAD_TIMER_EXP] = q.pin_drive[1];
    pad_ctl.out[PAD_LINK1_DONE] = q.pin_drive[2];
    pad_ctl.out[PAD_LINK2_DONE] = q.pin_drive[3];
    pad_ctl.out[PAD_LINK3_DONE] = q.pin_drive[4];
    if (running) begin
      pad_ctl.oe = DRIVEN_RUN;
      pad_ctl.pu = PULL_UP_RUN & id_gate;
      pad_ctl.pd = '0;
    end else begin
      pad_ctl.oe = '0;
      pad_ctl.pu = PULL_UP_RST & id_gate;
      pad_ctl.pd = PULL_DN_RST & id_gate;
    end
    pad_ctl.out = pad_ctl.out & pad_ctl.oe;
  end

  assign pad_out = pad_ctl.out;
  assign pad_oe_out = pad_ctl.oe;
  assign pad_pu_out = pad_ctl.pu;
  assign pad_pd_out = pad_ctl.pd;

  // Address decode and read mux
  always_comb begin
    rd_data = '0;
    addr_hit = 1'b1;
    case (paddr_in)
      OFS_STRAP_STATUS: begin
        rd_data[STS_STRAP_LSB +: 7] = q.strap;
        rd_data[STS_VALID_BIT] = q.valid;
        rd_data[STS_SYS_LOCK_BIT] = q.sys_lock;
        rd_data[STS_SDRAM_LOCK_BIT] = q.sdram_lock;
        // Board must leave test straps high; flag otherwise
        rd_data[STS_TEST_FAULT_BIT] = q.valid & ~(q.strap.test_strap_one
          & q.strap.test_strap_two & q.strap.test_strap_three);
        rd_data[STS_RUN_BIT] = running;
        rd_data[STS_BOOT_SEL_LEVEL_BIT] = running & pad_lvl[PAD_BOOT_MEM_SEL];
        rd_data[STS_HOLD_LEVEL_BIT] = running & pad_lvl[PAD_BUS_HOLD];
      end
      OFS_SYS_CFG: begin
        rd_data = q.sys_cfg;
      end
      OFS_SDRAM_CFG: begin
        rd_data = q.sdram_cfg;
      end
      OFS_IRQ_CFG: begin
        rd_data[IRQ_EN_LSB +: 4] = q.irq_en;
        rd_data[IRQ_LVL_LSB +: 4] = q.irq_lvl;
      end
      OFS_LINK_CFG: begin
        rd_data[0] = q.link_w4;
      end
      OFS_PIN_DRIVE: begin
        rd_data[4:0] = q.pin_drive;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Locked configuration registers refuse further writes unless the write strap is set
  always_comb begin
    wr_refused = 1'b0;
    if (pwrite_in && !q.strap.config_write_strap) begin
      if (paddr_in == OFS_SYS_CFG && q.sys_lock) begin
        wr_refused = 1'b1;
      end
      if (paddr_in == OFS_SDRAM_CFG && q.sdram_lock) begin
        wr_refused = 1'b1;
      end
    end
  end

  assign setup_phase = psel_in && !penable_in;
  assign access_wr = psel_in && penable_in && pwrite_in && !q.pslverr;

  // Next-state logic: capture sequence and register writes
  always_comb begin
    d = q;
    case (q.fsm)
      ST_RESET: begin
        // First edge after release: take the pad levels as modes
        d.strap = rsl_strap_t'(pad_lvl);
        d.valid = 1'b1;
        d.irq_en = {4{pad_lvl[1]}};
        d.irq_lvl = {4{pad_lvl[1]}};
        d.link_w4 = pad_lvl[2];
        d.cnt = '0;
        d.fsm = ST_SETTLE;
      end
      ST_SETTLE: begin
        // Keep strap termination briefly, then hand pads over
        if (q.cnt == 4'(RECONFIG_CYCLES - 1)) begin
          d.fsm = ST_RUN;
        end else begin
          d.cnt = q.cnt + 4'h1;
        end
      end
      ST_RUN: begin
        d.fsm = ST_RUN;
      end
      default: begin
        d.fsm = ST_RESET;
      end
    endcase

    // Read data and error prepared during the setup cycle
    if (setup_phase) begin
      d.prdata = (pwrite_in || !addr_hit) ? 32'h0000_0000 : rd_data;
      d.pslverr = !addr_hit || wr_refused;
    end

    // Writes take effect at the end of the access phase
    if (access_wr) begin
      case (paddr_in)
        OFS_SYS_CFG: begin
          d.sys_cfg = merge_bytes(q.sys_cfg, pwdata_in, pstrb_in);
          d.sys_lock = 1'b1;
        end
        OFS_SDRAM_CFG: begin
          d.sdram_cfg = merge_bytes(q.sdram_cfg, pwdata_in, pstrb_in);
          d.sdram_lock = 1'b1;
        end
        OFS_IRQ_CFG: begin
          if (pstrb_in[0]) begin
            d.irq_en = pwdata_in[IRQ_EN_LSB +: 4];
            d.irq_lvl = pwdata_in[IRQ_LVL_LSB +: 4];
          end
        end
        OFS_LINK_CFG: begin
          if (pstrb_in[0]) begin
            d.link_w4 = pwdata_in[0];
          end
        end
        OFS_PIN_DRIVE: begin
          if (pstrb_in[0]) begin
            d.pin_drive = pwdata_in[4:0];
          end
        end
        default: begin
          d.pin_drive = q.pin_drive;
        end
      endcase
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q.fsm <= ST_RESET;
      q.cnt <= '0;
      q.strap <= rsl_strap_t'(STRAP_DEFAULT);
      q.valid <= 1'b0;
      q.sys_cfg <= SYS_CFG_RST;
      q.sdram_cfg <= SDRAM_CFG_RST;
      q.sys_lock <= 1'b0;
      q.sdram_lock <= 1'b0;
      q.irq_en <= '0;
      q.irq_lvl <= '0;
      q.link_w4 <= 1'b0;
      q.pin_drive <= PIN_DRIVE_RST;
      q.prdata <= '0;
      q.pslverr <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // APB answer: no wait states
  assign pready_out = 1'b1;
  assign prdata_out = q.prdata;
  assign pslverr_out = q.pslverr && psel_in && penable_in;

  // Mode outputs from latched straps and configuration
  assign straps_out = q.strap;
  assign settings_valid_out = q.valid;
  assign boot_from_eprom_out = q.valid && !q.strap.boot_source_strap;
  assign boot_wait_host_out = q.valid && q.strap.boot_source_strap;
  assign irq_enable_out = q.irq_en;
  assign irq_level_out = q.irq_lvl;
  assign link_width_4bit_out = q.link_w4;
  assign system_config_reg_out = q.sys_cfg;
  assign sdram_config_reg_out = q.sdram_cfg;

endmodule

// ---- rsl_props.sv ----
// Checker for strap capture, pad sequencing and APB error timing
`timescale 1ns/1ps
module rsl_props import rsl_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pslverr_out,
  // Pads
  input wire logic [6:0] pad_in,
  input wire logic [6:0] pad_oe_out,
  input wire logic [6:0] pad_pu_out,
  input wire logic [6:0] pad_pd_out,
  input wire logic dsp_id_zero_in,
  // Settings
  input wire rsl_strap_t straps_out,
  input wire logic settings_valid_out,
  input wire logic boot_from_eprom_out,
  input wire logic boot_wait_host_out,
  input wire logic [3:0] irq_enable_out,
  input wire logic [3:0] irq_level_out,
  input wire logic link_width_4bit_out,
  input wire logic [31:0] system_config_reg_out,
  input wire logic [31:0] sdram_config_reg_out
);
  logic [6:0] gate;
  // Pulls on pads 0 and 3 present only when this device has ID zero
  assign gate = dsp_id_zero_in ? 7'h7f : 7'h76;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_capture; $rose(resetn_in) |=> settings_valid_out; endproperty
  a_capture: assert property (p_capture)
    else $error("settings not valid after release");
  property p_latch;
    $rose(resetn_in) && pad_in == $past(pad_in) && pad_in == $past(pad_in, 2)
      && pad_in == $past(pad_in, 3) && pad_in == $past(pad_in, 4)
      |=> straps_out == $past(pad_in);
  endproperty
  a_latch: assert property (p_latch)
    else $error("captured straps differ from pads");
  property p_hold;
    settings_valid_out && $past(settings_valid_out) |-> $stable(straps_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("straps changed after capture");
  property p_settle;
    $rose(resetn_in) |-> (pad_oe_out == 7'h00) [*6] ##1 (pad_oe_out == 7'h76);
  endproperty
  a_settle: assert property (p_settle)
    else $error("pads not returned to normal use in time");
  property p_run_pulls;
    pad_oe_out == 7'h76 |-> pad_pu_out == (7'h09 & gate) && pad_pd_out == 7'h00;
  endproperty
  a_run_pulls: assert property (p_run_pulls)
    else $error("wrong pulls in normal operation");
  property p_boot;
    settings_valid_out |-> boot_from_eprom_out == !straps_out.boot_source_strap
      && boot_wait_host_out == straps_out.boot_source_strap;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot outputs disagree with strap");
  property p_modes;
    $rose(settings_valid_out) |-> irq_enable_out == {4{straps_out.irq_startup_strap}}
      && irq_level_out == {4{straps_out.irq_startup_strap}}
      && link_width_4bit_out == straps_out.link_width_strap;
  endproperty
  a_modes: assert property (p_modes)
    else $error("startup modes disagree with straps");
  property p_err;
    pslverr_out |=> $stable(system_config_reg_out) && $stable(sdram_config_reg_out);
  endproperty
  a_err: assert property (p_err)
    else $error("refused access changed a config register");
  // Main scenarios reached
  c_wait: cover property ($rose(settings_valid_out) && straps_out.boot_source_strap);
  c_err: cover property (pslverr_out);
  c_run: cover property (pad_oe_out == 7'h76 && !dsp_id_zero_in);
endmodule
bind rsl_reset_strap_latch rsl_props u_props (.*);

// ---- rsl_board_model.sv ----
// Board strap model: overdrive resistors, internal pulls and pad resolution
`timescale 1ns/1ps
module rsl_board_model (
  // Clock
  input wire logic clk_in,
  // Board straps
  input wire logic [6:0] strap_en_in,
  input wire logic [6:0] strap_val_in,
  // Device pad controls
  input wire logic [6:0] pad_out_in,
  input wire logic [6:0] pad_oe_in,
  input wire logic [6:0] pad_pu_in,
  input wire logic [6:0] pad_pd_in,
  // Resolved pad level
  output logic [6:0] level_out
);
  logic flip_q = 1'b0;
  // Undriven, unpulled pads show a level that flips every cycle
  always @(posedge clk_in) flip_q <= ~flip_q;
  // Driver beats board strap, board strap beats internal pull
  assign level_out = (pad_oe_in & pad_out_in)
    | (~pad_oe_in & strap_en_in & strap_val_in)
    | (~pad_oe_in & ~strap_en_in & pad_pu_in)
    | (~pad_oe_in & ~strap_en_in & ~pad_pu_in & ~pad_pd_in & {7{flip_q}});
endmodule

// ---- tb.sv ----
// Testbench: strap capture, pad sequencing and config write lock
`timescale 1ns/1ps
module tb;
  import rsl_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dsp_id = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, sys_cfg, sdram_cfg;
  logic pready, pslverr, valid, eprom, host, lw4;
  logic [6:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, brd_en = 7'h00, brd_val = 7'h00;
  logic [3:0] irq_en, irq_lvl;
  rsl_strap_t straps;
  int n_errors = 0, check_count = 0, cyc = 0;
  rsl_reset_strap_latch dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe), .pad_pu_out(pad_pu),
    .pad_pd_out(pad_pd), .dsp_id_zero_in(dsp_id), .straps_out(straps),
    .settings_valid_out(valid), .boot_from_eprom_out(eprom), .boot_wait_host_out(host),
    .irq_enable_out(irq_en), .irq_level_out(irq_lvl), .link_width_4bit_out(lw4),
    .system_config_reg_out(sys_cfg), .sdram_config_reg_out(sdram_cfg));
  rsl_board_model board (.clk_in(clk_in), .strap_en_in(brd_en), .strap_val_in(brd_val),
    .pad_out_in(pad_out), .pad_oe_in(pad_oe), .pad_pu_in(pad_pu), .pad_pd_in(pad_pd),
    .level_out(pad_in));
  // Clock and hang guard
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Reset with board straps, pad terminations in reset and afterwards
  task automatic rst(input logic [6:0] en, input logic [6:0] val, input logic id);
    logic [6:0] g;
    g = id ? 7'h7f : 7'h76;
    @(posedge clk_in);
    resetn_in <= 1'b0; brd_en <= en; brd_val <= val; dsp_id <= id;
    repeat (8) @(posedge clk_in);
    check("oe_rst", pad_oe, 7'h00);
    check("pu_rst", pad_pu, 7'h70 & g);
    check("pd_rst", pad_pd, 7'h0f & g);
    resetn_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    check("oe_run", pad_oe, 7'h76);
    check("pu_run", pad_pu, 7'h09 & g);
    check("pd_run", pad_pd, 7'h00);
  endtask
  task automatic s_default;
    logic [31:0] r;
    logic e;
    logic [7:0] a;
    rst(7'h00, 7'h00, 1'b1);
    check("straps", straps, 7'h70);
    check("modes", {eprom, host, irq_en, irq_lvl, lw4}, 11'h400);
    // Both config registers take one write only
    for (int i = 0; i < 2; i++) begin
      a = 8'h04 + 8'(i * 4);
      apb(1'b1, a, 32'h1234_5678, r, e);
      check("wr1_err", e, 1'b0);
      apb(1'b1, a, 32'h0bad_0bad, r, e);
      check("wr2_err", e, 1'b1);
      apb(1'b0, a, 32'h0, r, e);
      check("rd_cfg", r, 32'h1234_5678);
      check("cfg_out", i == 0 ? sys_cfg : sdram_cfg, 32'h1234_5678);
    end
    apb(1'b0, 8'h18, 32'h0, r, e);
    check("unmapped", e, 1'b1);
    // Status: default straps, valid, both locks, run, pulled-up pads
    apb(1'b0, 8'h00, 32'h0, r, e);
    check("status", r, 32'h0003_0bf0);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    check("irq_cfg", r, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0, r, e);
    check("link_cfg", r, 32'h0000_0000);
  endtask
  task automatic s_over;
    logic [31:0] r;
    logic e;
    rst(7'h0f, 7'h0f, 1'b0);
    check("straps", straps, 7'h7f);
    check("modes", {eprom, host, irq_en, irq_lvl, lw4}, 11'h3ff);
    apb(1'b1, 8'h04, 32'h0000_00a5, r, e);
    apb(1'b1, 8'h04, 32'h0000_005a, r, e);
    check("wr2_err", e, 1'b0);
    @(posedge clk_in);
    check("cfg_out", sys_cfg, 32'h0000_005a);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    check("irq_cfg", r, 32'h0000_00ff);
    apb(1'b0, 8'h10, 32'h0, r, e);
    check("link_cfg", r, 32'h0000_0001);
    // Device now drives its output pads high
    apb(1'b1, 8'h14, 32'h0000_001f, r, e);
    @(posedge clk_in);
    check("pad_drive", pad_out, 7'h76);
    // Board changes its straps after capture
    brd_val <= 7'h00;
    repeat (10) @(posedge clk_in);
    check("straps_hold", straps, 7'h7f);
  endtask
  initial begin
    s_default();
    s_over();
    results();
  end
endmodule
